/* src/dual_timer_counter.sv */
// dual 16-bit timer/event counter with AXI4-Lite register access
// Contract
// - overflow of either timer sets its interrupt request automatically
// - pending request vectors only when globally enabled and no service active
// - vector taken after current instruction end plus two call cycles
// - after overflow counting continues from wrapped value
// - two independent 16-bit timer/counters
// - count is low and high byte; low carry increments high
// - run flag clear holds count; set resumes from held value
// - both count bytes read and writable while running
// - counter 0 counts port-3 bit 4, counter 1 bit 5
// - external interrupt pins 0 and 1 gate counters 0 and 1
// - reset input rising edge resets the timer logic
// - instruction cycle lasts 12 oscillator periods
// - auto-reload mode reloads stored byte on low-byte overflow
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module dual_timer_counter #(
    parameter int CYCLE_DIV = tc_pkg::OSC_PER_CYCLE
) (
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        reset_input,
    input  wire logic        counter0_pulse_input,
    input  wire logic        counter1_pulse_input,
    input  wire logic        ext_irq0_gate_pin,
    input  wire logic        ext_irq1_gate_pin,
    input  wire logic [7:0]  port3_latch,
    input  wire logic        instr_end,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             irq,
    output logic             vector_valid,
    output logic             vector_timer,
    output logic             instruction_cycle
);
    // ----------------------------------------------------------------
    // pin synchronisers and device reset edge
    // ----------------------------------------------------------------
    logic [5:0] sync1_reg;
    logic [5:0] sync2_reg;
    logic [1:0] pulse_prev_reg;
    logic       rst_prev_reg;
    wire  [5:0] pins_raw = {reset_input, ext_irq1_gate_pin, ext_irq0_gate_pin,
                            counter1_pulse_input, counter0_pulse_input, 1'b0};
    always_ff @(posedge mclk) begin
        sync1_reg <= pins_raw;
        sync2_reg <= sync1_reg;
    end
    wire [1:0] pulse_s = sync2_reg[2:1];
    wire [1:0] gate_s  = sync2_reg[4:3];
    wire       rst_s   = sync2_reg[5];
    wire       dev_rst = !resetn || (rst_s && !rst_prev_reg);

    // ----------------------------------------------------------------
    // instruction cycle prescaler
    // ----------------------------------------------------------------
    logic [7:0] div_reg;
    wire        tick = (div_reg == 8'(CYCLE_DIV - 1));
    always_ff @(posedge mclk) begin
        rst_prev_reg <= resetn ? rst_s : 1'b0;
        if (dev_rst) begin
            div_reg           <= 8'h00;
            instruction_cycle <= 1'b0;
            pulse_prev_reg    <= 2'h0;
        end else begin
            div_reg           <= tick ? 8'h00 : div_reg + 8'h01;
            instruction_cycle <= tick;
            if (tick) begin
                pulse_prev_reg <= pulse_s;
            end
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] cnt_low_reg  [2];
    logic [7:0] cnt_high_reg [2];
    logic [7:0] ctrl_reg;
    logic [7:0] reload_reg   [2];
    logic [1:0] irq_status_reg;
    logic [1:0] irq_enable_reg;
    logic       global_irq_enable;
    logic       in_service_reg;

    // ----------------------------------------------------------------
    // AXI4-Lite write path
    // ----------------------------------------------------------------
    logic [11:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic        aw_have_reg;
    logic        w_have_reg;
    wire         wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
    wire         wr_map  = (awaddr_reg[11:2] <= tc_pkg::ADDR_CPU_STATUS[11:2])
                           && (awaddr_reg[1:0] == 2'h0);
    function automatic logic wr_hit(input logic [11:0] a);
        return wr_fire && (awaddr_reg == a);
    endfunction
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            awaddr_reg    <= 12'h000;
            wdata_reg     <= tc_pkg::WORD_ZERO;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= tc_pkg::RESP_OKAY;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_have_reg && !s_axi_awready;
            s_axi_wready  <= !w_have_reg && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_have_reg  <= 1'b0;
                w_have_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_map ? tc_pkg::RESP_OKAY : tc_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    logic [3:0] wstrb_reg;
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            wstrb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wstrb_reg <= s_axi_wstrb;
        end
    end
    wire lane0 = wstrb_reg[0];

    // ----------------------------------------------------------------
    // timer/counter cores
    // ----------------------------------------------------------------
    logic [1:0] ovf;
    genvar n;
    generate
        for (n = 0; n < 2; n++) begin : g_tc
            wire run   = ctrl_reg[n*tc_pkg::CTRL_STRIDE + tc_pkg::CTRL_RUN];
            wire cmode = ctrl_reg[n*tc_pkg::CTRL_STRIDE + tc_pkg::CTRL_COUNTER];
            wire gmode = ctrl_reg[n*tc_pkg::CTRL_STRIDE + tc_pkg::CTRL_GATE];
            wire rmode = ctrl_reg[n*tc_pkg::CTRL_STRIDE + tc_pkg::CTRL_RELOAD];
            // pin functions need the port-3 latch bit at one
            wire pin_ok  = port3_latch[4 + n];
            wire gate_ok = !gmode || (gate_s[n] && port3_latch[2 + n]);
            wire fall    = pulse_prev_reg[n] && !pulse_s[n] && pin_ok;
            wire step    = tick && run && gate_ok && (cmode ? fall : 1'b1);
            wire low_c   = step && (cnt_low_reg[n] == 8'hFF);
            wire high_c  = low_c && (cnt_high_reg[n] == 8'hFF);
            assign ovf[n] = rmode ? low_c : high_c;
            wire [11:0] a_low  = n ? tc_pkg::ADDR_T1_LOW  : tc_pkg::ADDR_T0_LOW;
            wire [11:0] a_high = n ? tc_pkg::ADDR_T1_HIGH : tc_pkg::ADDR_T0_HIGH;
            always_ff @(posedge mclk) begin
                if (dev_rst) begin
                    cnt_low_reg[n]  <= tc_pkg::BYTE_ZERO;
                    cnt_high_reg[n] <= tc_pkg::BYTE_ZERO;
                    reload_reg[n]   <= tc_pkg::BYTE_ZERO;
                end else begin
                    // software write wins over the step in the same cycle
                    if (wr_hit(a_low) && lane0) begin
                        cnt_low_reg[n] <= wdata_reg[7:0];
                    end else if (low_c && rmode) begin
                        cnt_low_reg[n] <= reload_reg[n];
                    end else if (step) begin
                        cnt_low_reg[n] <= cnt_low_reg[n] + 8'h01;
                    end
                    if (wr_hit(a_high) && lane0) begin
                        cnt_high_reg[n] <= wdata_reg[7:0];
                    end else if (low_c && !rmode) begin
                        cnt_high_reg[n] <= cnt_high_reg[n] + 8'h01;
                    end
                    if (wr_hit(tc_pkg::ADDR_RELOAD) && wstrb_reg[n]) begin
                        reload_reg[n] <= wdata_reg[n*8 +: 8];
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // control, interrupt status and vectoring
    // ----------------------------------------------------------------
    logic [2:0] call_cnt_reg;
    logic       call_busy_reg;
    logic       call_wait_reg;
    logic       call_sel_reg;
    wire [1:0]  pend    = irq_status_reg & irq_enable_reg;
    wire        can_vec = global_irq_enable && !in_service_reg && (pend != 2'h0)
                          && !call_wait_reg && !call_busy_reg;
    wire [1:0]  clr     = wr_hit(tc_pkg::ADDR_IRQ_CLEAR) ? wdata_reg[1:0] : 2'h0;
    always_ff @(posedge mclk) begin
        if (dev_rst) begin
            ctrl_reg          <= 8'h00;
            irq_status_reg    <= 2'h0;
            irq_enable_reg    <= 2'h0;
            global_irq_enable <= 1'b0;
            in_service_reg    <= 1'b0;
            call_cnt_reg      <= 3'h0;
            call_busy_reg     <= 1'b0;
            call_wait_reg     <= 1'b0;
            call_sel_reg      <= 1'b0;
            vector_valid      <= 1'b0;
            vector_timer      <= 1'b0;
            irq               <= 1'b0;
        end else begin
            if (wr_hit(tc_pkg::ADDR_CTRL) && lane0) begin
                ctrl_reg <= wdata_reg[7:0];
            end
            if (wr_hit(tc_pkg::ADDR_IRQ_ENABLE) && lane0) begin
                irq_enable_reg <= wdata_reg[1:0];
            end
            if (wr_hit(tc_pkg::ADDR_CPU_CTRL) && lane0) begin
                global_irq_enable <= wdata_reg[tc_pkg::CPU_GLOBAL_EN];
                if (!wdata_reg[tc_pkg::CPU_IN_SERVICE]) begin
                    in_service_reg <= 1'b0;
                end
            end
            // set wins over clear
            irq_status_reg <= (irq_status_reg & ~clr) | ovf;
            irq            <= ((irq_status_reg | ovf) & irq_enable_reg) != 2'h0;
            vector_valid   <= 1'b0;
            if (can_vec) begin
                call_wait_reg <= 1'b1;
                call_sel_reg  <= !pend[0];
            end else if (call_wait_reg && instr_end) begin
                call_wait_reg <= 1'b0;
                call_busy_reg <= 1'b1;
                call_cnt_reg  <= tc_pkg::CALL_CYCLES;
            end else if (call_busy_reg && tick) begin
                call_cnt_reg <= call_cnt_reg - 3'h1;
                if (call_cnt_reg == 3'h1) begin
                    call_busy_reg  <= 1'b0;
                    in_service_reg <= 1'b1;
                    vector_valid   <= 1'b1;
                    vector_timer   <= call_sel_reg;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read path
    // ----------------------------------------------------------------
    wire [11:0] ra = s_axi_araddr;
    wire        r_map = (ra[11:2] <= tc_pkg::ADDR_CPU_STATUS[11:2]) && (ra[1:0] == 2'h0);
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = tc_pkg::WORD_ZERO;
        unique case (ra)
            tc_pkg::ADDR_T0_LOW:     rd_mux[7:0] = cnt_low_reg[0];
            tc_pkg::ADDR_T0_HIGH:    rd_mux[7:0] = cnt_high_reg[0];
            tc_pkg::ADDR_T1_LOW:     rd_mux[7:0] = cnt_low_reg[1];
            tc_pkg::ADDR_T1_HIGH:    rd_mux[7:0] = cnt_high_reg[1];
            tc_pkg::ADDR_CTRL:       rd_mux[7:0] = ctrl_reg;
            tc_pkg::ADDR_RELOAD:     rd_mux[15:0] = {reload_reg[1], reload_reg[0]};
            tc_pkg::ADDR_IRQ_STATUS: rd_mux[1:0] = irq_status_reg;
            tc_pkg::ADDR_IRQ_ENABLE: rd_mux[1:0] = irq_enable_reg;
            tc_pkg::ADDR_CPU_CTRL:   rd_mux[1:0] = {in_service_reg, global_irq_enable};
            tc_pkg::ADDR_CPU_STATUS: rd_mux[2:0] = {call_busy_reg, call_wait_reg,
                                                    in_service_reg};
            default:                 rd_mux = tc_pkg::WORD_ZERO;
        endcase
    end
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= tc_pkg::WORD_ZERO;
            s_axi_rresp   <= tc_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !s_axi_arvalid ? 1'b1
                             : (!s_axi_rvalid && !s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_mux;
                s_axi_rresp   <= r_map ? tc_pkg::RESP_OKAY : tc_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

/* src/tc_pkg.sv */
// package: register map, fields and timing for the dual timer/counter
package tc_pkg;
    localparam int          OSC_PER_CYCLE   = 12;
    localparam logic [11:0] ADDR_T0_LOW     = 12'h000;
    localparam logic [11:0] ADDR_T0_HIGH    = 12'h004;
    localparam logic [11:0] ADDR_T1_LOW     = 12'h008;
    localparam logic [11:0] ADDR_T1_HIGH    = 12'h00C;
    localparam logic [11:0] ADDR_CTRL       = 12'h010;
    localparam logic [11:0] ADDR_RELOAD     = 12'h014;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h018;
    localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h01C;
    localparam logic [11:0] ADDR_IRQ_CLEAR  = 12'h020;
    localparam logic [11:0] ADDR_CPU_CTRL   = 12'h024;
    localparam logic [11:0] ADDR_CPU_STATUS = 12'h028;
    // ctrl fields, per timer n at bit n*4
    localparam int          CTRL_RUN        = 0;
    localparam int          CTRL_COUNTER    = 1;
    localparam int          CTRL_GATE       = 2;
    localparam int          CTRL_RELOAD     = 3;
    localparam int          CTRL_STRIDE     = 4;
    localparam int          CPU_IN_SERVICE  = 1;
    localparam int          CPU_GLOBAL_EN   = 0;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
    localparam logic [7:0]  BYTE_ZERO       = 8'h00;
    localparam logic [31:0] WORD_ZERO       = 32'h00000000;
    // service call length in instruction cycles
    localparam logic [2:0]  CALL_CYCLES     = 3'h2;
endpackage

/* sim/dual_timer_counter_chk.sv */
// checker: port-level assertions for the dual timer/counter
`timescale 1ns/1ps
module dual_timer_counter_chk #(
    parameter int CYCLE_DIV = 12
) (
    input wire logic        mclk,
    input wire logic        resetn,
    input wire logic        reset_input,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        irq,
    input wire logic        vector_valid,
    input wire logic        instruction_cycle
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn || reset_input);
    a_cycle_period: assert property (instruction_cycle |-> ##CYCLE_DIV instruction_cycle)
        else $error("instruction cycle period wrong");
    a_cycle_gap: assert property (instruction_cycle |=> !instruction_cycle [*8])
        else $error("instruction cycle pulse too soon");
    a_vector_pulse: assert property (vector_valid |=> !vector_valid [*8])
        else $error("vector repeated during service");
    a_vector_pending: assert property ($rose(vector_valid) |-> $past(irq))
        else $error("vector without enabled request");
    a_write_resp: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:4] s_axi_bvalid)
        else $error("write response late");
    a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_aw_ready_drop: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("write address ready held");
    a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data not released");
    a_reset_quiet: assert property (disable iff (1'b0)
        !resetn |=> !irq && !vector_valid && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs active after reset");
    c_irq: cover property ($rose(irq));
    c_vector: cover property (vector_valid);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind dual_timer_counter dual_timer_counter_chk #(.CYCLE_DIV(CYCLE_DIV)) chk_u (.mclk, .resetn,
    .reset_input, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .irq, .vector_valid,
    .instruction_cycle);

/* sim/cpu_model.sv */
// cpu side model: flags instruction completion after 1, 2 or 4 cycles
`timescale 1ns/1ps
module cpu_model (
    input  wire logic mclk,
    input  wire logic resetn,
    input  wire logic instruction_cycle,
    output logic      instr_end
);
    int left;
    initial instr_end = 1'b0;
    always @(posedge mclk) begin
        instr_end <= 1'b0;
        if (!resetn) begin
            left <= 1;
        end else if (instruction_cycle) begin
            if (left <= 1) begin
                instr_end <= 1'b1;
                left <= 1 << ($urandom % 3);
            end else begin
                left <= left - 1;
            end
        end
    end
endmodule

/* sim/dual_timer_counter_tb.sv */
// testbench: dual timer/counter over AXI4-Lite and pins
`timescale 1ns/1ps
module dual_timer_counter_tb;
    logic        mclk = 1'b0, resetn = 1'b0, reset_input = 1'b0, instr_end;
    logic        counter0_pulse_input = 1'b0, counter1_pulse_input = 1'b0;
    logic        ext_irq0_gate_pin = 1'b0, ext_irq1_gate_pin = 1'b0;
    logic [7:0]  port3_latch = 8'h00;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, vector_valid, vector_timer;
    logic        instruction_cycle;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr, br;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [15:0] a, b;
    int          error_cnt = 0, total_checks = 0, n, k;
    dual_timer_counter #(.CYCLE_DIV(12)) dut_u (.mclk, .resetn, .reset_input,
        .counter0_pulse_input, .counter1_pulse_input, .ext_irq0_gate_pin, .ext_irq1_gate_pin,
        .port3_latch, .instr_end, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .irq, .vector_valid, .vector_timer, .instruction_cycle);
    cpu_model cpu_u (.mclk, .resetn, .instruction_cycle, .instr_end);
    initial forever #12.5 mclk = ~mclk;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic stall;
        error_cnt++;
        finish_test();
    endtask
    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic [31:0] ctl(int tm, logic [3:0] f);
        return {28'h0, f} << (tc_pkg::CTRL_STRIDE * tm);
    endfunction
    function automatic logic in_win(logic [15:0] s, int k, logic [15:0] v);
        return (16'(v - s) >= 16'(k - 1)) && (16'(v - s) <= 16'(k + 2));
    endfunction
    task automatic wr(input logic [11:0] ad, input logic [31:0] d);
        int t;
        @(posedge mclk);
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        t = 0;
        do begin
            @(posedge mclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            t++;
        end while (s_axi_bvalid !== 1'b1 && t < 64);
        br = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (t >= 64) stall();
    endtask
    task automatic rd(input logic [11:0] ad);
        int t;
        @(posedge mclk);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        t = 0;
        do begin
            @(posedge mclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            t++;
        end while (s_axi_rvalid !== 1'b1 && t < 64);
        rv = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (t >= 64) stall();
    endtask
    task automatic wr16(input int tm, input logic [15:0] v);
        wr(tc_pkg::ADDR_T0_LOW + 12'(8 * tm), {24'h0, v[7:0]});
        wr(tc_pkg::ADDR_T0_HIGH + 12'(8 * tm), {24'h0, v[15:8]});
    endtask
    task automatic rd16(input int tm, output logic [15:0] v);
        logic [7:0] h;
        int t;
        t = 0;
        do begin
            rd(tc_pkg::ADDR_T0_HIGH + 12'(8 * tm));
            h = rv[7:0];
            rd(tc_pkg::ADDR_T0_LOW + 12'(8 * tm));
            v[7:0] = rv[7:0];
            rd(tc_pkg::ADDR_T0_HIGH + 12'(8 * tm));
            t++;
        end while (rv[7:0] !== h && t < 8);
        if (rv[7:0] !== h) stall();
        v[15:8] = h;
    endtask
    task automatic tick(input int k);
        int t;
        repeat (k) begin
            t = 0;
            do begin
                @(posedge mclk);
                t++;
            end while (instruction_cycle !== 1'b1 && t < 40);
            if (t >= 40) stall();
        end
    endtask
    task automatic pulses(input int k);
        repeat (k) begin
            counter0_pulse_input <= 1'b1;
            counter1_pulse_input <= 1'b1;
            repeat (30) @(posedge mclk);
            counter0_pulse_input <= 1'b0;
            counter1_pulse_input <= 1'b0;
            repeat (30) @(posedge mclk);
        end
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(64));
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        repeat (2) @(posedge mclk);
        a = {8'($urandom % 255), 8'hFC | 8'($urandom % 4)};
        wr16(0, a);
        chk("write ok", br, tc_pkg::RESP_OKAY);
        wr(tc_pkg::ADDR_CTRL, ctl(0, 4'h1));
        k = 4 + $urandom % 20;
        tick(k);
        wr(tc_pkg::ADDR_CTRL, 32'h0);
        rd16(0, b);
        chk("t0 step", in_win(a, k, b), 1'b1);
        repeat (40) @(posedge mclk);
        rd16(0, a);
        chk("t0 held", a, b);
        wr(tc_pkg::ADDR_CTRL, ctl(0, 4'h1));
        tick(3);
        rd16(0, b);
        chk("t0 resume", in_win(a, 3, b), 1'b1);
        $display("timer mode done");
        wr(tc_pkg::ADDR_CTRL, 32'h0);
        wr16(1, 16'hFFFE);
        wr(tc_pkg::ADDR_IRQ_ENABLE, 32'h2);
        wr(tc_pkg::ADDR_CTRL, ctl(1, 4'h1));
        n = 0;
        while (irq !== 1'b1 && n < 200) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 200) stall();
        rd(tc_pkg::ADDR_IRQ_STATUS);
        chk("status", rv, 32'h2);
        rd16(1, b);
        chk("wrapped", b < 16'h0010, 1'b1);
        k = 0;
        repeat (100) begin
            @(posedge mclk);
            if (vector_valid === 1'b1) k++;
        end
        chk("no vector", 32'(k), 32'h0);
        wr(tc_pkg::ADDR_CPU_CTRL, 32'h1);
        n = 0;
        while (vector_valid !== 1'b1 && n < 400) begin
            @(posedge mclk);
            n++;
        end
        chk("vector t1", {n > 12, n < 400, vector_timer}, 3'h7);
        if (n >= 400) stall();
        wr(tc_pkg::ADDR_CPU_CTRL, 32'h0);
        wr(tc_pkg::ADDR_CTRL, 32'h0);
        wr(tc_pkg::ADDR_IRQ_ENABLE, 32'h0);
        repeat (2) @(posedge mclk);
        chk("irq masked", irq, 1'b0);
        wr(tc_pkg::ADDR_IRQ_CLEAR, 32'h2);
        rd(tc_pkg::ADDR_IRQ_STATUS);
        chk("cleared", rv, 32'h0);
        wr(tc_pkg::ADDR_RELOAD, 32'h0000F000);
        wr16(1, 16'h00FE);
        wr(tc_pkg::ADDR_CTRL, ctl(1, 4'h9));
        tick(6);
        wr(tc_pkg::ADDR_CTRL, 32'h0);
        rd16(1, b);
        chk("reload", {b[15:8], b[7:0] >= 8'hF0, b[7:0] < 8'hFE}, 10'h003);
        $display("interrupt done");
        wr16(0, 16'h0000);
        wr(tc_pkg::ADDR_CTRL, ctl(0, 4'h3));
        pulses(3);
        rd16(0, b);
        chk("latch off", b, 16'h0000);
        port3_latch <= 8'h34;
        k = 1 + $urandom % 6;
        pulses(k);
        rd16(0, b);
        chk("pulse count", b, 16'(k));
        wr(tc_pkg::ADDR_CTRL, ctl(0, 4'h5));
        rd16(0, a);
        tick(4);
        rd16(0, b);
        chk("gate low", b, a);
        ext_irq0_gate_pin <= 1'b1;
        tick(4);
        rd16(0, a);
        chk("gate high", a != b, 1'b1);
        $display("counter and gate done");
        rd(12'h3F0);
        chk("unmapped", {rr, rv}, {tc_pkg::RESP_SLVERR, 32'h0});
        wr(12'h3F0, 32'h0);
        chk("write err", br, tc_pkg::RESP_SLVERR);
        reset_input <= 1'b1;
        repeat (20) @(posedge mclk);
        reset_input <= 1'b0;
        rd(tc_pkg::ADDR_CTRL);
        chk("pin reset ctrl", rv, 32'h0);
        rd16(0, b);
        chk("pin reset count", b, 16'h0);
        $display("bus and reset done");
        finish_test();
    end
endmodule
